/* File: tmr0_pkg.sv */
// Package of constants for the Timer0 clock and prescaler block
`default_nettype none
package tmr0_pkg;
   // ==========================================================
   // Register offsets and widths
   localparam int         DATA_W           = 8;
   localparam logic [7:0] PRESC_COUNT_ADDR = 8'h0A;
   // ==========================================================
   // Mode register field positions
   localparam int MODE_LOW_OSC_BIT  = 7;
   localparam int MODE_SPARE_BIT    = 6;
   localparam int MODE_CLK_SRC_BIT  = 5;
   localparam int MODE_EDGE_BIT     = 4;
   localparam int MODE_ASSIGN_BIT   = 3;
   localparam int MODE_RATE_LSB     = 0;
   localparam int RATE_W            = 3;
   // ==========================================================
   // Reset values and the Timer0 top count
   localparam logic [7:0] MODE_RESET        = 8'h3F;
   localparam logic [7:0] PRESC_COUNT_RESET = 8'hFF;
   localparam logic [7:0] TIMER_RESET       = 8'h00;
   localparam logic [7:0] TIMER_TOP         = 8'hFF;
   localparam logic [7:0] RDATA_IDLE        = 8'h00;
endpackage
`default_nettype wire

/* File: presc_if.sv */
// Interface between the Timer0 control logic and the shared prescaler
`default_nettype none
interface presc_if;
   logic                            in_tick;
   logic [tmr0_pkg::RATE_W-1:0]     rate;
   logic                            to_wdt;
   logic                            wdt_int_mode;
   logic                            out_tick;
   logic [tmr0_pkg::DATA_W-1:0]     count;
   modport ctrl  (output in_tick, output rate, output to_wdt, output wdt_int_mode,
                  input out_tick, input count);
   modport presc (input in_tick, input rate, input to_wdt, input wdt_int_mode,
                  output out_tick, output count);
endinterface
`default_nettype wire

/* File: presc_div.sv */
// Shared 8-stage power-of-two prescaler with live count
`default_nettype none
module presc_div (
   // Clock and reset
   input  wire logic sys_clk_i,
   input  wire logic reset_i,
   // Control side
   presc_if.presc    pif
);
   import tmr0_pkg::*;
   // ==========================================================
   // Divide ratio decode
   logic [7:0] count_q;
   logic [7:0] count_d;
   logic [3:0] stages;
   logic [8:0] mask_wide;
   logic [7:0] mask;
   // Watchdog reset timeout divides one stage less
   assign stages    = (pif.to_wdt && !pif.wdt_int_mode) ? {1'b0, pif.rate}
                                                        : {1'b0, pif.rate} + 4'h1;
   assign mask_wide = (9'h001 << stages) - 9'h001;
   assign mask      = mask_wide[7:0];
   assign count_d   = pif.in_tick ? count_q + 8'h01 : count_q;
   assign pif.out_tick = pif.in_tick && ((count_d & mask) == 8'h00);
   assign pif.count    = count_q;

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         count_q <= PRESC_COUNT_RESET;
      end else begin
         count_q <= count_d;
      end
   end

   // ==========================================================
   // Checks
   a_out_needs_in: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      pif.out_tick |-> pif.in_tick)
      else $error("prescaler output without an input tick");
   a_out_aligned: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (pif.out_tick && $stable(mask)) |=> ((count_q & $past(mask)) == 8'h00))
      else $error("prescaler output not on a ratio boundary");
   a_wdt_one_to_one: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (pif.in_tick && pif.to_wdt && !pif.wdt_int_mode && pif.rate == 3'h0) |-> pif.out_tick)
      else $error("watchdog reset ratio 1:1 missed a tick");
endmodule
`default_nettype wire

/* File: tmr0_clk_presc.sv */
// Timer0 clock source selection, prescaler routing and Timer0 counter
`default_nettype none
module tmr0_clk_presc (
   // Clock and reset
   input  wire logic                        sys_clk_i,
   input  wire logic                        reset_i,
   // Dedicated mode instructions
   input  wire logic                        mode_wr_i,
   input  wire logic [tmr0_pkg::DATA_W-1:0] mode_wdata_i,
   output logic [tmr0_pkg::DATA_W-1:0]      mode_rdata_o,
   // Register page read
   input  wire logic                        page_rd_i,
   input  wire logic [7:0]                  page_addr_i,
   output logic [tmr0_pkg::DATA_W-1:0]      page_rdata_o,
   // Clock sources
   input  wire logic                        inst_tick_i,
   input  wire logic                        ext_timer_clock_pin_i,
   input  wire logic                        low_osc_clk_i,
   // Timer0 control and status
   input  wire logic                        timer_run_i,
   input  wire logic                        overflow_flag_clr_i,
   output logic [tmr0_pkg::DATA_W-1:0]      timer_value_o,
   output logic                             timer_zero_overflow_flag_o,
   // Watchdog side
   input  wire logic                        wdt_tick_i,
   input  wire logic                        wdt_timeout_int_i,
   output logic                             wdt_presc_tick_o
);
   import tmr0_pkg::*;

   // ==========================================================
   // Mode register
   logic [7:0] timer_zero_mode_q;
   logic       low_osc_clock_select;
   logic       clock_source_select;
   logic       count_edge_select;
   logic       prescaler_assign;
   logic [2:0] prescaler_rate;

   assign low_osc_clock_select = timer_zero_mode_q[MODE_LOW_OSC_BIT];
   assign clock_source_select  = timer_zero_mode_q[MODE_CLK_SRC_BIT];
   assign count_edge_select    = timer_zero_mode_q[MODE_EDGE_BIT];
   assign prescaler_assign     = timer_zero_mode_q[MODE_ASSIGN_BIT];
   assign prescaler_rate       = timer_zero_mode_q[MODE_RATE_LSB +: RATE_W];

   // Not on the data page: only the write instruction port reaches it
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         timer_zero_mode_q <= MODE_RESET;
      end else if (mode_wr_i) begin
         timer_zero_mode_q <= mode_wdata_i;
      end
   end
   assign mode_rdata_o = timer_zero_mode_q;

   // ==========================================================
   // Pin synchronisers and edge detect
   // Reset low to match the idle pins, else reset would fake an edge
   logic [2:0] ext_sync_q;
   logic [2:0] low_sync_q;

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         ext_sync_q <= 3'h0;
         low_sync_q <= 3'h0;
      end else begin
         ext_sync_q <= {ext_sync_q[1:0], ext_timer_clock_pin_i};
         low_sync_q <= {low_sync_q[1:0], low_osc_clk_i};
      end
   end

   // Only stages 1 and 2 are looked at; stage 0 is metastable
   logic src_now;
   logic src_prev;
   logic slow_edge;
   logic src_tick;

   assign src_now   = low_osc_clock_select ? low_sync_q[1] : ext_sync_q[1];
   assign src_prev  = low_osc_clock_select ? low_sync_q[2] : ext_sync_q[2];
   assign slow_edge = count_edge_select ? (src_prev && !src_now)
                                        : (!src_prev && src_now);
   assign src_tick  = clock_source_select ? slow_edge : inst_tick_i;

   // ==========================================================
   // Prescaler routing
   presc_if pif ();
   logic timer_tick;

   assign pif.in_tick      = prescaler_assign ? wdt_tick_i : (src_tick && timer_run_i);
   assign pif.rate         = prescaler_rate;
   assign pif.to_wdt       = prescaler_assign;
   assign pif.wdt_int_mode = wdt_timeout_int_i;
   // Timer0 bypasses the prescaler while the watchdog owns it
   assign timer_tick = prescaler_assign ? (src_tick && timer_run_i) : pif.out_tick;

   presc_div u_presc (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .pif       (pif)
   );

   // ==========================================================
   // Timer0 counter and overflow flag
   logic [7:0] timer_q;
   logic       flag_q;
   logic       wdt_tick_q;
   logic [7:0] page_rdata_q;
   logic       overflow;
   logic       flag_d;

   assign overflow = timer_tick && (timer_q == TIMER_TOP);
   // A wrap in the clearing cycle keeps the flag set
   assign flag_d   = overflow || (flag_q && !overflow_flag_clr_i);

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         timer_q      <= TIMER_RESET;
         flag_q       <= 1'b0;
         wdt_tick_q   <= 1'b0;
         page_rdata_q <= RDATA_IDLE;
      end else begin
         timer_q      <= timer_tick ? timer_q + 8'h01 : timer_q;
         flag_q       <= flag_d;
         wdt_tick_q   <= prescaler_assign && pif.out_tick;
         page_rdata_q <= (page_rd_i && page_addr_i == PRESC_COUNT_ADDR) ? pif.count
                                                                        : RDATA_IDLE;
      end
   end

   assign timer_value_o              = timer_q;
   assign timer_zero_overflow_flag_o = flag_q;
   assign wdt_presc_tick_o           = wdt_tick_q;
   assign page_rdata_o               = page_rdata_q;

   // ==========================================================
   // Checks
   a_mode_write: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      mode_wr_i |=> mode_rdata_o == $past(mode_wdata_i))
      else $error("mode write not taken");
   a_count_read: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (page_rd_i && page_addr_i == 8'h0A) |=> page_rdata_o == $past(pif.count))
      else $error("prescaler count read wrong");
   a_flag_sticky: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (flag_q && !overflow_flag_clr_i) |=> flag_q)
      else $error("overflow flag dropped without clear");
   a_wrap_sets_flag: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (timer_q == 8'hFF) ##1 (timer_q == 8'h00) |-> timer_zero_overflow_flag_o)
      else $error("wrap did not set overflow flag");
   a_timer_step: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      !$stable(timer_q) |-> timer_q == $past(timer_q) + 8'h01)
      else $error("timer moved other than by one");
   a_inst_source: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (!clock_source_select && !prescaler_assign && timer_run_i) |-> pif.in_tick == inst_tick_i)
      else $error("instruction clock not routed to prescaler");
   a_fall_edge: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (clock_source_select && !low_osc_clock_select && count_edge_select && src_tick)
         |-> ($past(ext_sync_q[1]) && !ext_sync_q[1]))
      else $error("falling edge select counted wrong edge");
   a_rise_edge: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (clock_source_select && !low_osc_clock_select && !count_edge_select && src_tick)
         |-> (!$past(ext_sync_q[1]) && ext_sync_q[1]))
      else $error("rising edge select counted wrong edge");
   a_low_fall: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (clock_source_select && low_osc_clock_select && count_edge_select && src_tick)
         |-> ($past(low_sync_q[1]) && !low_sync_q[1]))
      else $error("low oscillator falling edge counted wrong");
   a_low_rise: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (clock_source_select && low_osc_clock_select && !count_edge_select && src_tick)
         |-> (!$past(low_sync_q[1]) && low_sync_q[1]))
      else $error("low oscillator rising edge counted wrong");
   a_pin_ignored: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (clock_source_select && low_osc_clock_select && (low_sync_q[2] == low_sync_q[1]))
         |-> !src_tick)
      else $error("pin counted while low oscillator selected");

   // ==========================================================
   // Checks on routing, counter and status
   // Watchdog ownership must leave Timer0 running at the raw source rate
   a_timer_bypass: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (prescaler_assign && timer_run_i && src_tick) |=> timer_q == $past(timer_q) + 8'h01)
      else $error("timer missed a bypassed source tick");
   a_timer_prescaled: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (!prescaler_assign && pif.out_tick) |=> timer_q == $past(timer_q) + 8'h01)
      else $error("timer missed a prescaler tick");
   a_timer_hold: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      !timer_tick |=> timer_q == $past(timer_q))
      else $error("timer moved without a tick");
   a_wdt_isolated: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      !prescaler_assign |=> !wdt_presc_tick_o)
      else $error("watchdog tick while prescaler owned by timer");
   a_wdt_pulse: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (prescaler_assign && pif.out_tick) |=> wdt_presc_tick_o)
      else $error("watchdog tick lost");
   a_flag_clear: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (overflow_flag_clr_i && !overflow) |=> !flag_q)
      else $error("overflow flag not cleared");
   a_flag_set_wins: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      overflow |=> flag_q)
      else $error("overflow did not set the flag");
   a_page_idle: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      !(page_rd_i && page_addr_i == PRESC_COUNT_ADDR) |=> page_rdata_o == RDATA_IDLE)
      else $error("page read data not idle");
   a_mode_hold: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      !mode_wr_i |=> $stable(mode_rdata_o))
      else $error("mode register changed without a write");
endmodule
`default_nettype wire

/* File: clk_src_model.sv */
// Partner model of the external timer clock pin and the low-frequency oscillator
`default_nettype none
module clk_src_model (
   // Clock, reset and burst request
   input  wire logic       sys_clk_i,
   input  wire logic       reset_i,
   input  wire logic       go_i,
   input  wire logic       lo_sel_i,
   input  wire logic [7:0] edges_i,
   // Driven clock lines and burst busy flag
   output var  logic       pin_o,
   output var  logic       lo_o,
   output var  logic       busy_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // ==========================================================
   // Burst driver
   // Burst ends high, so rising and falling counts differ by one
   task automatic drive(input logic v);
      repeat (4) @(posedge sys_clk_i);
      #1;
      if (lo_sel_i) begin
         lo_o = v;
      end else begin
         pin_o = v;
      end
   endtask
   initial begin
      pin_o = 1'b0;
      lo_o = 1'b0;
      busy_o = 1'b0;
   end
   // Lines start low, stay high after a burst ends, and go back low on reset
   always @(posedge reset_i) begin
      pin_o = 1'b0;
      lo_o = 1'b0;
   end
   always @(posedge go_i) begin
      busy_o = 1'b1;
      for (int i = 0; i < int'(edges_i); i++) begin
         if (i > 0) drive(1'b0);
         drive(1'b1);
      end
      busy_o = 1'b0;
   end
endmodule
`default_nettype wire

/* File: tmr0_clk_presc_test.sv */
// Self-checking bench for the Timer0 clock and prescaler block
`default_nettype none
module tmr0_clk_presc_test;
   timeunit 1ns;
   timeprecision 100ps;
   import tmr0_pkg::*;
   logic       sys_clk_i = 0, reset_i = 1, mode_wr_i = 0, page_rd_i = 0;
   logic       inst_tick_i = 0, timer_run_i = 0, flag_clr = 0, wdt_tick_i = 0;
   logic       wdt_int = 0, go = 0, lo_sel = 0, pin, lo, busy, flag, wdt_pt;
   logic [7:0] mode_wdata_i = 0, page_addr_i = 0, mode_rd, page_rd, tval, v;
   int         fails = 0, tests_run = 0, wdt_seen = 0;
   int         w_rate [4] = '{0, 1, 7, 7};
   int         w_int  [4] = '{0, 1, 0, 1};
   int         w_tick [4] = '{4, 8, 129, 257};
   logic [7:0] x_mode [6] = '{8'h28, 8'h38, 8'hA8, 8'hB8, 8'hA8, 8'h08};
   int         x_lo   [6] = '{0, 0, 1, 1, 0, 0};
   int         x_exp  [6] = '{4, 3, 4, 3, 0, 0};
   tmr0_clk_presc i_dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .mode_wr_i(mode_wr_i),
      .mode_wdata_i(mode_wdata_i), .mode_rdata_o(mode_rd), .page_rd_i(page_rd_i),
      .page_addr_i(page_addr_i), .page_rdata_o(page_rd), .inst_tick_i(inst_tick_i),
      .ext_timer_clock_pin_i(pin), .low_osc_clk_i(lo), .timer_run_i(timer_run_i),
      .overflow_flag_clr_i(flag_clr), .timer_value_o(tval),
      .timer_zero_overflow_flag_o(flag), .wdt_tick_i(wdt_tick_i),
      .wdt_timeout_int_i(wdt_int), .wdt_presc_tick_o(wdt_pt));
   clk_src_model i_src (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .go_i(go),
      .lo_sel_i(lo_sel), .edges_i(8'h04), .pin_o(pin), .lo_o(lo), .busy_o(busy));
   always #5 sys_clk_i = ~sys_clk_i;
   always @(posedge sys_clk_i) if (wdt_pt === 1'b1) wdt_seen++;
   // ==========================================================
   // Access tasks
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic summarize;
      $display("mismatches %0d of %0d comparisons", fails, tests_run);
      if (fails == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask
   task automatic do_reset;
      reset_i = 1;
      timer_run_i = 0;
      step(12);
      reset_i = 0;
   endtask
   task automatic wr_mode(input logic [7:0] d);
      mode_wr_i = 1;
      mode_wdata_i = d;
      step(1);
      mode_wr_i = 0;
   endtask
   task automatic rd_page(input logic [7:0] a);
      page_rd_i = 1;
      page_addr_i = a;
      step(1);
      page_rd_i = 0;
      v = page_rd;
      step(1);
   endtask
   // Back-to-back source events, one per cycle
   task automatic events(input int n, input bit w);
      for (int i = 0; i < n; i++) begin
         if (w) wdt_tick_i = 1;
         else inst_tick_i = 1;
         step(1);
      end
      inst_tick_i = 0;
      wdt_tick_i = 0;
      step(2);
   endtask
   task automatic ext(input int l);
      int k;
      lo_sel = l[0];
      go = 1;
      step(1);
      go = 0;
      for (k = 0; k < 200 && busy; k++) step(1);
      if (busy) begin
         fails++;
         summarize();
      end
      step(6);
   endtask
   // ==========================================================
   // Scenarios
   initial begin
      do_reset();
      check(mode_rd, 8'h3F);
      rd_page(8'h0A);
      check(v, 8'hFF);
      rd_page(8'h0B);
      check(v, 8'h00);
      for (int r = 0; r < 8; r++) begin
         do_reset();
         wr_mode(8'(r));
         check(mode_rd, 8'(r));
         timer_run_i = 1;
         events((2 << r) * 2 + 1, 0);
         check(tval, 8'h03);
         rd_page(8'h0A);
         check(v, 8'((4 << r) & 255));
      end
      do_reset();
      wr_mode(8'h08);
      timer_run_i = 1;
      events(255, 0);
      check({7'h0, flag}, 8'h00);
      events(1, 0);
      check(tval, 8'h00);
      step(5);
      check({7'h0, flag}, 8'h01);
      flag_clr = 1;
      step(1);
      flag_clr = 0;
      step(1);
      check({7'h0, flag}, 8'h00);
      // Wrap and clear in one cycle: the set wins
      events(255, 0);
      flag_clr = 1;
      inst_tick_i = 1;
      step(1);
      flag_clr = 0;
      inst_tick_i = 0;
      step(1);
      check(tval, 8'h00);
      check({7'h0, flag}, 8'h01);
      for (int c = 0; c < 4; c++) begin
         do_reset();
         wr_mode(8'h08 | 8'(w_rate[c]));
         wdt_int = w_int[c][0];
         wdt_seen = 0;
         events(w_tick[c], 1);
         check(8'(wdt_seen), 8'h02 << (c == 0));
      end
      // Pin, low oscillator, both edges, and unselected sources
      for (int c = 0; c < 6; c++) begin
         do_reset();
         wr_mode(x_mode[c]);
         timer_run_i = 1;
         ext(x_lo[c]);
         check(tval, 8'(x_exp[c]));
      end
      summarize();
   end
endmodule
`default_nettype wire
